// ==== common/jtgtap_consts.svh ====
// constants of the boundary-scan test access port
`ifndef JTGTAP_CONSTS_SVH
`define JTGTAP_CONSTS_SVH

// scan register widths
`define JTGTAP_IR_W 8
`define JTGTAP_BYP_W 1
`define JTGTAP_ID_W 32
`define JTGTAP_BSR_W 113

// instruction opcodes
`define JTGTAP_OP_EXTEST 8'h00
`define JTGTAP_OP_IDCODE 8'h21
`define JTGTAP_OP_SAMPLE 8'h05
`define JTGTAP_OP_CLAMP 8'h07
`define JTGTAP_OP_HIGHZ 8'h03
`define JTGTAP_OP_BYPASS 8'hff

// value loaded into the instruction stage in capture-ir
`define JTGTAP_IR_CAPTURE 8'h01
// value loaded into the bypass stage in capture-dr
`define JTGTAP_BYP_CAPTURE 1'h0

// identification word layout
`define JTGTAP_ID_REV_MSB 31
`define JTGTAP_ID_REV_LSB 28
`define JTGTAP_ID_PART_MSB 27
`define JTGTAP_ID_PART_LSB 12
`define JTGTAP_ID_VEND_MSB 11
`define JTGTAP_ID_VEND_LSB 1
`define JTGTAP_ID_MARK_BIT 0
`define JTGTAP_ID_MARK 1'h1

// consecutive tms-high rising edges that always reach test-logic-reset
`define JTGTAP_RESET_EDGES 5

`endif

// ==== common/jtgtap_pkg.sv ====
// types of the boundary-scan test access port
`include "jtgtap_consts.svh"

package jtgtap_pkg;

  typedef enum logic [3:0] {
    JTGTAP_TLR = 4'b0000,
    JTGTAP_RTI = 4'b0001,
    JTGTAP_SEL_DR = 4'b0010,
    JTGTAP_CAP_DR = 4'b0011,
    JTGTAP_SHF_DR = 4'b0100,
    JTGTAP_EX1_DR = 4'b0101,
    JTGTAP_PAU_DR = 4'b0110,
    JTGTAP_EX2_DR = 4'b0111,
    JTGTAP_UPD_DR = 4'b1000,
    JTGTAP_SEL_IR = 4'b1001,
    JTGTAP_CAP_IR = 4'b1010,
    JTGTAP_SHF_IR = 4'b1011,
    JTGTAP_EX1_IR = 4'b1100,
    JTGTAP_PAU_IR = 4'b1101,
    JTGTAP_EX2_IR = 4'b1110,
    JTGTAP_UPD_IR = 4'b1111
  } jtgtap_state_t;

  // modes handed from the test clock domain to the core domain
  typedef struct packed {
    logic drive;
    logic highz;
  } jtgtap_mode_t;

  // rising-edge state of the test clock domain
  typedef struct packed {
    logic [`JTGTAP_IR_W-1:0] ir_shift;
    logic [`JTGTAP_IR_W-1:0] ir_active;
    jtgtap_mode_t mode;
    logic [`JTGTAP_BYP_W-1:0] byp;
    logic [`JTGTAP_ID_W-1:0] id_shift;
    logic [`JTGTAP_BSR_W-1:0] bsr_shift;
    logic [`JTGTAP_BSR_W-1:0] bsr_upd;
  } jtgtap_tck_t;

  // falling-edge state of the test clock domain
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jtgtap_tdo_t;

  // core clock domain state
  typedef struct packed {
    logic [`JTGTAP_BSR_W-1:0] ball_out;
    logic [`JTGTAP_BSR_W-1:0] ball_oe;
    logic test_active;
  } jtgtap_core_t;

endpackage : jtgtap_pkg

// ==== design/jtgtap_sync.sv ====
// two flip-flop level synchroniser of parameterised width

module jtgtap_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] st_reg;
  logic [1:0][W-1:0] st_next;

  // the first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    if (!rst_n) begin
      st_next = '0;
    end else if (en) begin
      st_next[0] = d;
      st_next[1] = st_reg[0];
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign q = st_reg[1];

endmodule : jtgtap_sync

// ==== design/jtgtap_fsm.sv ====
// sixteen-state test access port controller

module jtgtap_fsm (
  input wire logic tck,
  input wire logic por_n,
  input wire logic en,
  input wire logic tms,
  output jtgtap_pkg::jtgtap_state_t state
);

  jtgtap_pkg::jtgtap_state_t st_reg;
  jtgtap_pkg::jtgtap_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!por_n) begin
      st_next = jtgtap_pkg::JTGTAP_TLR;
    end else if (en) begin
      unique case (st_reg)
        jtgtap_pkg::JTGTAP_TLR: st_next = tms ? jtgtap_pkg::JTGTAP_TLR : jtgtap_pkg::JTGTAP_RTI;
        jtgtap_pkg::JTGTAP_RTI: st_next = tms ? jtgtap_pkg::JTGTAP_SEL_DR : jtgtap_pkg::JTGTAP_RTI;
        jtgtap_pkg::JTGTAP_SEL_DR: st_next = tms ? jtgtap_pkg::JTGTAP_SEL_IR : jtgtap_pkg::JTGTAP_CAP_DR;
        jtgtap_pkg::JTGTAP_CAP_DR: st_next = tms ? jtgtap_pkg::JTGTAP_EX1_DR : jtgtap_pkg::JTGTAP_SHF_DR;
        jtgtap_pkg::JTGTAP_SHF_DR: st_next = tms ? jtgtap_pkg::JTGTAP_EX1_DR : jtgtap_pkg::JTGTAP_SHF_DR;
        jtgtap_pkg::JTGTAP_EX1_DR: st_next = tms ? jtgtap_pkg::JTGTAP_UPD_DR : jtgtap_pkg::JTGTAP_PAU_DR;
        jtgtap_pkg::JTGTAP_PAU_DR: st_next = tms ? jtgtap_pkg::JTGTAP_EX2_DR : jtgtap_pkg::JTGTAP_PAU_DR;
        jtgtap_pkg::JTGTAP_EX2_DR: st_next = tms ? jtgtap_pkg::JTGTAP_UPD_DR : jtgtap_pkg::JTGTAP_SHF_DR;
        jtgtap_pkg::JTGTAP_UPD_DR: st_next = tms ? jtgtap_pkg::JTGTAP_SEL_DR : jtgtap_pkg::JTGTAP_RTI;
        jtgtap_pkg::JTGTAP_SEL_IR: st_next = tms ? jtgtap_pkg::JTGTAP_TLR : jtgtap_pkg::JTGTAP_CAP_IR;
        jtgtap_pkg::JTGTAP_CAP_IR: st_next = tms ? jtgtap_pkg::JTGTAP_EX1_IR : jtgtap_pkg::JTGTAP_SHF_IR;
        jtgtap_pkg::JTGTAP_SHF_IR: st_next = tms ? jtgtap_pkg::JTGTAP_EX1_IR : jtgtap_pkg::JTGTAP_SHF_IR;
        jtgtap_pkg::JTGTAP_EX1_IR: st_next = tms ? jtgtap_pkg::JTGTAP_UPD_IR : jtgtap_pkg::JTGTAP_PAU_IR;
        jtgtap_pkg::JTGTAP_PAU_IR: st_next = tms ? jtgtap_pkg::JTGTAP_EX2_IR : jtgtap_pkg::JTGTAP_PAU_IR;
        jtgtap_pkg::JTGTAP_EX2_IR: st_next = tms ? jtgtap_pkg::JTGTAP_UPD_IR : jtgtap_pkg::JTGTAP_SHF_IR;
        jtgtap_pkg::JTGTAP_UPD_IR: st_next = tms ? jtgtap_pkg::JTGTAP_SEL_DR : jtgtap_pkg::JTGTAP_RTI;
      endcase
    end
  end

  always_ff @(posedge tck) begin
    st_reg <= st_next;
  end

  assign state = st_reg;

endmodule : jtgtap_fsm

// ==== design/jtgtap_top.sv ====
// boundary-scan test access port with instruction, bypass, id and boundary registers
//
// Functional notes
// - five rising tck edges with tms high always land in test-logic-reset
// - tap reset leaves memory pins on their functional path, accepted anytime
// - power-up reset puts the tap in reset so tdo starts undriven
// - one scan register between tdi and tdo, picked by the active instruction
// - tdi taken on tck rise, tdo changed on tck fall
// - eight-bit instruction stage, becomes active only in update-ir
// - active instruction becomes idcode at power-up and in test-logic-reset
// - capture-ir loads binary 01 into the two low stage bits
// - one-bit bypass stage, cleared to zero on capture
// - boundary chain is 113 cells, inputs, bidirectionals and reserved balls
// - capture-dr loads ring values, shift-dr shifts the chain
// - tdi enters each register at its msb, lsb drives tdo
// - idcode capture loads the fixed 32-bit id word, then shifts out
// - id word: revision 31:28, part 27:12, vendor 11:1, bit 0 one
// - opcode shifted in shift-ir takes effect on passing update-ir
// - extest drives held cell values onto output balls from update-ir on
// - high-z floats every output and uses the bypass stage
// - clamp drives held chain values and uses the bypass stage
// - sample/preload snapshots balls without disturbing memory, then shifts out
// - bypass uses the one-bit stage, one bit of delay
// - opcodes extest 00, idcode 21, sample/preload 05 in hex
// - opcodes clamp 07, high-z 03, bypass ff in hex
// - tdo driven only in shift-ir and shift-dr, floating otherwise
// - controller stays in test-logic-reset while tms high, test logic idle

`include "jtgtap_consts.svh"

module jtgtap_top #(
  // arbitrary identification values
  parameter logic [3:0] ID_REVISION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_VENDOR = 11'h0ab,
  // cells that face output or bidirectional balls
  parameter logic [`JTGTAP_BSR_W-1:0] OUT_CELL_MASK = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [`JTGTAP_BSR_W-1:0] ring_in,
  input wire logic [`JTGTAP_BSR_W-1:0] func_out,
  input wire logic [`JTGTAP_BSR_W-1:0] func_oe,
  output logic [`JTGTAP_BSR_W-1:0] ball_out,
  output logic [`JTGTAP_BSR_W-1:0] ball_oe,
  output logic test_active
);

  localparam int XW = `JTGTAP_BSR_W + 2;
  localparam int CW = `JTGTAP_BSR_W + 2;

  // crossings into the test clock domain
  logic [XW-1:0] tck_sync_d;
  logic [XW-1:0] tck_sync_q;
  logic por_n;
  logic tck_en;
  logic [`JTGTAP_BSR_W-1:0] ring_tck;

  // crossings into the core domain
  logic [CW-1:0] core_sync_q;
  jtgtap_pkg::jtgtap_mode_t mode_core;
  logic [`JTGTAP_BSR_W-1:0] upd_core;

  jtgtap_pkg::jtgtap_state_t state;
  jtgtap_pkg::jtgtap_tck_t t_reg;
  jtgtap_pkg::jtgtap_tck_t t_next;
  jtgtap_pkg::jtgtap_tdo_t o_reg;
  jtgtap_pkg::jtgtap_tdo_t o_next;
  jtgtap_pkg::jtgtap_core_t c_reg;
  jtgtap_pkg::jtgtap_core_t c_next;

  logic [`JTGTAP_ID_W-1:0] id_word;
  logic sel_bsr;
  logic sel_id;

  // the reset and enable levels and the ring pins all pass two tck flops;
  // this synchroniser runs unreset so it can carry the reset itself
  assign tck_sync_d = {rst_n, clk_en, ring_in};

  jtgtap_sync #(
    .W(XW)
  ) u_tck_sync (
    .clk(tck),
    .rst_n(1'b1),
    .en(1'b1),
    .d(tck_sync_d),
    .q(tck_sync_q)
  );

  assign por_n = tck_sync_q[XW-1];
  assign tck_en = tck_sync_q[XW-2];
  assign ring_tck = tck_sync_q[`JTGTAP_BSR_W-1:0];

  jtgtap_fsm u_fsm (
    .tck(tck),
    .por_n(por_n),
    .en(tck_en),
    .tms(tms),
    .state(state)
  );

  always_comb begin
    id_word = '0;
    id_word[`JTGTAP_ID_REV_MSB:`JTGTAP_ID_REV_LSB] = ID_REVISION;
    id_word[`JTGTAP_ID_PART_MSB:`JTGTAP_ID_PART_LSB] = ID_PART;
    id_word[`JTGTAP_ID_VEND_MSB:`JTGTAP_ID_VEND_LSB] = ID_VENDOR;
    id_word[`JTGTAP_ID_MARK_BIT] = `JTGTAP_ID_MARK;
  end

  always_comb begin
    sel_bsr = (t_reg.ir_active == `JTGTAP_OP_EXTEST) || (t_reg.ir_active == `JTGTAP_OP_SAMPLE);
    sel_id = (t_reg.ir_active == `JTGTAP_OP_IDCODE);
  end

  // rising tck edge: capture, shift and update of every scan register
  always_comb begin
    t_next = t_reg;
    if (!por_n) begin
      t_next.ir_shift = '0;
      t_next.ir_active = `JTGTAP_OP_IDCODE;
      t_next.mode = '0;
      t_next.byp = '0;
      t_next.id_shift = '0;
      t_next.bsr_shift = '0;
      t_next.bsr_upd = '0;
    end else if (tck_en) begin
      unique case (state)
        jtgtap_pkg::JTGTAP_TLR: begin
          t_next.ir_active = `JTGTAP_OP_IDCODE;
          t_next.mode = '0;
        end
        jtgtap_pkg::JTGTAP_CAP_IR: begin
          t_next.ir_shift = `JTGTAP_IR_CAPTURE;
        end
        jtgtap_pkg::JTGTAP_SHF_IR: begin
          t_next.ir_shift = {tdi, t_reg.ir_shift[`JTGTAP_IR_W-1:1]};
        end
        jtgtap_pkg::JTGTAP_UPD_IR: begin
          t_next.ir_active = t_reg.ir_shift;
          t_next.mode.drive = (t_reg.ir_shift == `JTGTAP_OP_EXTEST) || (t_reg.ir_shift == `JTGTAP_OP_CLAMP);
          t_next.mode.highz = (t_reg.ir_shift == `JTGTAP_OP_HIGHZ);
        end
        jtgtap_pkg::JTGTAP_CAP_DR: begin
          if (sel_bsr) begin
            t_next.bsr_shift = ring_tck;
          end else if (sel_id) begin
            t_next.id_shift = id_word;
          end else begin
            t_next.byp = `JTGTAP_BYP_CAPTURE;
          end
        end
        jtgtap_pkg::JTGTAP_SHF_DR: begin
          if (sel_bsr) begin
            t_next.bsr_shift = {tdi, t_reg.bsr_shift[`JTGTAP_BSR_W-1:1]};
          end else if (sel_id) begin
            t_next.id_shift = {tdi, t_reg.id_shift[`JTGTAP_ID_W-1:1]};
          end else begin
            t_next.byp = tdi;
          end
        end
        jtgtap_pkg::JTGTAP_UPD_DR: begin
          // held cells change only here; preload fills them before extest
          if (sel_bsr) begin
            t_next.bsr_upd = t_reg.bsr_shift;
          end
        end
        jtgtap_pkg::JTGTAP_RTI,
        jtgtap_pkg::JTGTAP_SEL_DR,
        jtgtap_pkg::JTGTAP_EX1_DR,
        jtgtap_pkg::JTGTAP_PAU_DR,
        jtgtap_pkg::JTGTAP_EX2_DR,
        jtgtap_pkg::JTGTAP_SEL_IR,
        jtgtap_pkg::JTGTAP_EX1_IR,
        jtgtap_pkg::JTGTAP_PAU_IR,
        jtgtap_pkg::JTGTAP_EX2_IR: begin
          t_next = t_reg;
        end
      endcase
    end
  end

  always_ff @(posedge tck) begin
    t_reg <= t_next;
  end

  // falling tck edge: tdo takes the lsb of the register in the path
  always_comb begin
    o_next = o_reg;
    if (!por_n) begin
      o_next.tdo = 1'b0;
      o_next.tdo_oe = 1'b0;
    end else if (tck_en) begin
      o_next.tdo_oe = (state == jtgtap_pkg::JTGTAP_SHF_IR) || (state == jtgtap_pkg::JTGTAP_SHF_DR);
      if (state == jtgtap_pkg::JTGTAP_SHF_IR) begin
        o_next.tdo = t_reg.ir_shift[0];
      end else if (state == jtgtap_pkg::JTGTAP_SHF_DR) begin
        if (sel_bsr) begin
          o_next.tdo = t_reg.bsr_shift[0];
        end else if (sel_id) begin
          o_next.tdo = t_reg.id_shift[0];
        end else begin
          o_next.tdo = t_reg.byp[0];
        end
      end else begin
        o_next.tdo = 1'b0;
      end
    end
  end

  always_ff @(negedge tck) begin
    o_reg <= o_next;
  end

  assign tdo = o_reg.tdo;
  assign tdo_oe = o_reg.tdo_oe;

  // mode and held cells are static while a test vector is applied, so a
  // per-bit level crossing is enough; a vector settles within three core edges
  jtgtap_sync #(
    .W(CW)
  ) u_core_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .en(clk_en),
    .d({t_reg.mode, t_reg.bsr_upd}),
    .q(core_sync_q)
  );

  assign mode_core = core_sync_q[CW-1:CW-2];
  assign upd_core = core_sync_q[`JTGTAP_BSR_W-1:0];

  // core domain: ball drivers pick the functional or the test value.
  // the register stage adds one core cycle to the functional path
  always_comb begin
    c_next = c_reg;
    if (!rst_n) begin
      c_next.ball_out = '0;
      c_next.ball_oe = '0;
      c_next.test_active = 1'b0;
    end else if (clk_en) begin
      c_next.test_active = mode_core.drive || mode_core.highz;
      if (mode_core.highz) begin
        c_next.ball_out = func_out;
        c_next.ball_oe = '0;
      end else if (mode_core.drive) begin
        c_next.ball_out = (upd_core & OUT_CELL_MASK) | (func_out & ~OUT_CELL_MASK);
        c_next.ball_oe = OUT_CELL_MASK | (func_oe & ~OUT_CELL_MASK);
      end else begin
        c_next.ball_out = func_out;
        c_next.ball_oe = func_oe;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    c_reg <= c_next;
  end

  assign ball_out = c_reg.ball_out;
  assign ball_oe = c_reg.ball_oe;
  assign test_active = c_reg.test_active;

endmodule : jtgtap_top

// ==== tb/jtgtap_assertions.sv ====
// concurrent checks on the pins of the boundary-scan test access port
`include "jtgtap_consts.svh"

module jtgtap_assertions #(
  parameter logic [`JTGTAP_BSR_W-1:0] OUT_CELL_MASK = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [`JTGTAP_BSR_W-1:0] ring_in,
  input wire logic [`JTGTAP_BSR_W-1:0] func_out,
  input wire logic [`JTGTAP_BSR_W-1:0] func_oe,
  input wire logic [`JTGTAP_BSR_W-1:0] ball_out,
  input wire logic [`JTGTAP_BSR_W-1:0] ball_oe,
  input wire logic test_active
);
  tdo_idle_a: assert property (@(negedge tck) disable iff (!rst_n) !tdo_oe |-> !tdo)
    else $error("tdo not low while undriven");
  // eight edges leave margin for the two-flop enable crossing
  tms_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
    (tms && clk_en) [*8] |-> !tdo_oe)
    else $error("tdo still driven after tms held high");
  oe_change_a: assert property (@(posedge tck) disable iff (!rst_n)
    $changed(tdo_oe) |-> $past(tms) != tdo_oe)
    else $error("tdo enable moved against tms");
  oe_hold_a: assert property (@(posedge tck) disable iff (!rst_n)
    tdo_oe && !tms |=> tdo_oe)
    else $error("tdo enable dropped inside shift");
  follow_func_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !test_active && !$past(test_active) && $past(clk_en) && $past(rst_n)
    |-> ball_out == $past(func_out) && ball_oe == $past(func_oe))
    else $error("balls left the functional path");
  test_oe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    test_active |-> ball_oe == '0 || (ball_oe & OUT_CELL_MASK) == OUT_CELL_MASK)
    else $error("ball enables wrong in test mode");
  freeze_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(clk_en) && $past(rst_n) |-> $stable(ball_out) && $stable(ball_oe))
    else $error("balls moved while clock disabled");
  test_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(test_active) |-> $past(clk_en))
    else $error("test mode changed while clock disabled");
endmodule : jtgtap_assertions

bind jtgtap_top jtgtap_assertions #(.OUT_CELL_MASK(OUT_CELL_MASK)) u_jtgtap_assertions (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .ring_in(ring_in), .func_out(func_out), .func_oe(func_oe), .ball_out(ball_out),
  .ball_oe(ball_oe), .test_active(test_active)
);

// ==== tb/jtgtap_tester.sv ====
// board tester model that drives the test access port
module jtgtap_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_last;

  // tms and tdi idle high: both have pull-ups, tck rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    line_last = 1'b0;
  end

  // change after fall, 32 ns period
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    tms = tms_v;
    tdi = tdi_v;
    #16;
    // an undriven tdo shows the inverse of its last level
    tdo_v = tdo_oe ? tdo : ~line_last;
    line_last = tdo_v;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask : step

  // hold tms for n rising edges
  task automatic idle(input logic tms_v, input int n);
    logic o;
    repeat (n) step(tms_v, 1'b1, o);
  endtask : idle

  // one scan from run-test/idle back to it, lsb first
  task automatic scan(input logic is_ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (is_ir) begin
      step(1'b1, 1'b1, o);
    end
    idle(1'b0, 2);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : scan
endmodule : jtgtap_tester

// ==== tb/tb.sv ====
// self-checking bench for the boundary-scan test access port
`include "jtgtap_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // identity values are arbitrary
  localparam logic [3:0] ID_REV = 4'h6;
  localparam logic [15:0] ID_DEV = 16'h4c3a;
  localparam logic [10:0] ID_VND = 11'h2d5;
  localparam logic [127:0] ID_EXP = {96'h0, ID_REV, ID_DEV, ID_VND, 1'b1};
  localparam logic [112:0] OUT_MASK = {17'h0_0000, 96'hffff_ffff_ffff_ffff_ffff_ffff};
  localparam logic [112:0] PAT_A = {17'h1_2345, 96'h89ab_cdef_0123_4567_89ab_cdef};
  localparam logic [112:0] PAT_B = ~PAT_A;
  // cells off the mask keep the functional enable, which is PAT_A here
  localparam logic [112:0] DRV_OE = OUT_MASK | (PAT_A & ~OUT_MASK);
  localparam logic [7:0] OPS [4] = '{`JTGTAP_OP_BYPASS, 8'h5a, `JTGTAP_OP_CLAMP, `JTGTAP_OP_HIGHZ};
  localparam logic [112:0] OE_EXP [4] = '{PAT_A, PAT_A, DRV_OE, 113'h0};
  localparam logic [3:0] ACT_EXP = 4'b1100;
  logic core_clk, rst_n, clk_en, tck, tms, tdi, tdo, tdo_oe, test_active;
  logic [112:0] ring_in, func_out, func_oe, ball_out, ball_oe;
  logic [127:0] dout;
  int fails;
  int num_checks;

  jtgtap_top #(.ID_REVISION(ID_REV), .ID_PART(ID_DEV), .ID_VENDOR(ID_VND), .OUT_CELL_MASK(OUT_MASK)) u_jtgtap_top (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_in(ring_in), .func_out(func_out), .func_oe(func_oe), .ball_out(ball_out),
    .ball_oe(ball_oe), .test_active(test_active)
  );
  jtgtap_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // mode and held cells cross two flops and a register into the core domain
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask : settle

  task automatic load_ir(input logic [7:0] op);
    u_tester.scan(1'b1, 8, {120'h0, op}, dout);
    check("ir_capture", {120'h0, `JTGTAP_IR_CAPTURE}, {120'h0, dout[7:0]});
  endtask : load_ir

  initial begin
    #1_000_000;
    fails++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    ring_in = PAT_B;
    func_out = PAT_A;
    func_oe = PAT_A;
    fails = 0;
    num_checks = 0;
    // tck has to run while reset is low
    fork
      repeat (20) @(negedge core_clk);
      u_tester.idle(1'b1, 8);
    join
    @(negedge core_clk);
    rst_n = 1'b1;
    u_tester.idle(1'b1, 3);
    check("tdo_oe_reset", 128'h0, {127'h0, tdo_oe});
    u_tester.idle(1'b0, 1);
    u_tester.scan(1'b0, 32, 128'h0, dout);
    check("idcode", ID_EXP, {96'h0, dout[31:0]});
    load_ir(`JTGTAP_OP_SAMPLE);
    u_tester.scan(1'b0, 113, {15'h0, PAT_A}, dout);
    check("sample_capture", {15'h0, PAT_B}, {15'h0, dout[112:0]});
    @(negedge core_clk);
    func_out = PAT_B;
    settle();
    check("sample_pins", {15'h0, PAT_B}, {15'h0, ball_out});
    load_ir(`JTGTAP_OP_EXTEST);
    settle();
    check("extest_oe", {15'h0, DRV_OE}, {15'h0, ball_oe});
    check("extest_out", {15'h0, PAT_A & OUT_MASK}, {15'h0, ball_out & OUT_MASK});
    @(negedge core_clk);
    ring_in = PAT_A;
    func_out = PAT_A;
    u_tester.scan(1'b0, 113, {15'h0, PAT_B}, dout);
    check("extest_capture", {15'h0, PAT_A}, {15'h0, dout[112:0]});
    settle();
    check("extest_update", {15'h0, PAT_B & OUT_MASK}, {15'h0, ball_out & OUT_MASK});
    for (int k = 0; k < 4; k++) begin
      load_ir(OPS[k]);
      u_tester.scan(1'b0, 9, 128'h1a5, dout);
      check("bypass_path", 128'h14a, {119'h0, dout[8:0]});
      settle();
      check("mode_oe", {15'h0, OE_EXP[k]}, {15'h0, ball_oe});
      check("mode_active", {127'h0, ACT_EXP[k]}, {127'h0, test_active});
      if (k < 3) begin
        check("mode_out", {15'h0, (k == 2 ? PAT_B : PAT_A) & OUT_MASK}, {15'h0, ball_out & OUT_MASK});
      end
    end
    u_tester.idle(1'b1, 5);
    settle();
    check("reset_pins", {15'h0, PAT_A}, {15'h0, ball_oe});
    u_tester.idle(1'b0, 1);
    u_tester.scan(1'b0, 32, 128'h0, dout);
    check("idcode_after_reset", ID_EXP, {96'h0, dout[31:0]});
    @(negedge core_clk);
    clk_en = 1'b0;
    func_out = PAT_B;
    repeat (3) @(negedge core_clk);
    check("frozen_pins", {15'h0, PAT_A}, {15'h0, ball_out});
    clk_en = 1'b1;
    settle();
    check("resumed_pins", {15'h0, PAT_B}, {15'h0, ball_out});
    complete_run();
  end
endmodule : tb
